//--- pkg/line_ctl_pkg.sv
// constants and types shared by the line control logic
package line_ctl_pkg;
    // ==================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CS_RESET_EDGES = 16;
    localparam int CLK_FAIL_CLEAR_NS = 400000;
    localparam int CLK_FAIL_CLEAR_CYC = CLK_FAIL_CLEAR_NS / CLK_PERIOD_NS;
    localparam int SLOT_NS = 15625;
    localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_SLOTS = 2;
    localparam int FRAME_SLOTS = 13;
    localparam int MASK_SLOTS = 1;
    localparam int STROBE_CYC = STROBE_SLOTS * SLOT_CYC;
    // ==================================================
    // commands of the serial command port
    localparam logic [7:0] CMD_CLK_WR = 8'h46;
    localparam logic [7:0] CMD_CLK_RD = 8'h47;
    localparam logic [7:0] CMD_CHSEL_WR = 8'h4A;
    localparam logic [7:0] CMD_CHSEL_RD = 8'h4B;
    localparam logic [7:0] CMD_LATCH_WR = 8'h52;
    localparam logic [7:0] CMD_PIN_RD = 8'h53;
    localparam logic [7:0] CMD_DIR_WR = 8'h54;
    localparam logic [7:0] CMD_DIR_RD = 8'h55;
    localparam logic [7:0] CMD_MUX_WR = 8'hC8;
    localparam logic [7:0] CMD_MUX_RD = 8'hC9;
    // ==================================================
    // field positions and channel and pin counts
    localparam int CLK_SRC_BIT = 4;
    localparam int MUX_EN_BIT = 7;
    localparam int STB_POL_BIT = 6;
    localparam int TRI_BIT = 5;
    localparam int ALT_RD_BIT = 5;
    localparam int FAIL_RD_BIT = 7;
    localparam int NUM_CH = 4;
    localparam int NUM_PINS = 5;
    // ==================================================
    // values after reset
    localparam logic [7:0] CLK_CFG_RST = 8'h00;
    localparam logic [7:0] CHAN_SEL_RST = 8'h0F;
    localparam logic [7:0] MUX_CFG_RST = 8'h00;
    localparam logic [5:0] DIR_RST = 6'h00;
    localparam logic [4:0] LATCH_RST = 5'h00;
    // ==================================================
    // serial frame states
    typedef enum logic [1:0] {st_cmd, st_wdata, st_rdata} frame_state_t;
endpackage

//--- src/slot_tick.sv
// divider giving one enable pulse per multiplex slot
`timescale 1ns/1ps
module slot_tick
    import line_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic wrap;

    assign wrap = (cnt_q == 16'(SLOT_CYC - 1));
    // idle count starts at one so the first slot is as long as the rest
    assign cnt_d = !run ? 16'h0001 : (wrap ? 16'h0000 : cnt_q + 16'h0001);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick <= run && wrap;
        end
    end
endmodule // slot_tick

//--- src/line_channel.sv
// one channel: pin latches, direction and detect latches
`timescale 1ns/1ps
module line_channel
    import line_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wr_latch,
    input wire logic wr_dir,
    input wire logic [7:0] wr_data,
    input wire logic en_first,
    input wire logic en_alt,
    input wire logic mux_active,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [7:0] readback,
    output logic second_status
);
    logic [5:0] dir_q;
    logic detect_first_q;
    logic detect_alt_q;
    logic [4:0] level;
    logic tri_on;

    assign tri_on = dir_q[TRI_BIT];
    // first detect bit replaces the raw pin level
    assign level = {pin_in[4:1], detect_first_q};
    // output pins read back their latch
    assign readback = {2'b00, detect_alt_q,
        (dir_q[4:0] & pin_out) | (~dir_q[4:0] & level)};

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            dir_q <= DIR_RST;
            pin_out <= LATCH_RST;
            pin_oe <= 5'h00;
            detect_first_q <= 1'b0;
            detect_alt_q <= 1'b0;
            second_status <= 1'b0;
        end
        else
        begin
            if (wr_latch)
                pin_out <= wr_data[4:0];
            if (wr_dir)
                dir_q <= wr_data[5:0];
            pin_oe <= tri_on ? 5'h00 : dir_q[4:0];
            if (en_first)
                detect_first_q <= pin_in[0];
            if (en_alt)
                detect_alt_q <= pin_in[0];
            second_status <= mux_active ? detect_alt_q : pin_in[1];
        end
    end

    property p_readback_latch;
        @(posedge core_clk) disable iff (!reset_n)
        dir_q[2] |-> readback[2] == pin_out[2];
    endproperty
    a_readback_latch: assert property (p_readback_latch)
        else $error("output pin does not read back its latch");
    property p_hold_first;
        @(posedge core_clk) disable iff (!reset_n)
        !en_first |=> detect_first_q == $past(detect_first_q);
    endproperty
    a_hold_first: assert property (p_hold_first)
        else $error("first detect bit moved while disabled");
endmodule // line_channel

//--- src/line_io_ctrl.sv
// serial command port, channel select, clock and detect multiplex control
`timescale 1ns/1ps
module line_io_ctrl
    import line_ctl_pkg::*;
#(
    parameter int CLK_LOCK_CYCLES = line_ctl_pkg::CLK_FAIL_CLEAR_CYC
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic serial_port_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic [19:0] line_io_in,
    output logic [19:0] line_io_out,
    output logic [19:0] line_io_oe,
    output logic mux_strobe_out,
    output logic mux_strobe_oe,
    output logic [3:0] realtime_second_status,
    output logic clock_source_select,
    output logic clock_fail_flag
);
    // ==================================================
    // serial command port
    logic sclk_prev_q;
    logic cs_prev_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] tx_q;
    logic cs_reset_q;
    frame_state_t state_q;
    frame_state_t state_d;
    logic int_rst_n;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic full_byte;
    logic commit;
    logic is_write;
    logic is_read;
    logic [7:0] rd_value;

    assign int_rst_n = reset_n && !cs_reset_q;
    assign sclk_rise = !cs_n && serial_port_clock && !sclk_prev_q;
    assign sclk_fall = !cs_n && !serial_port_clock && sclk_prev_q;
    assign cs_fall = !cs_n && cs_prev_q;
    assign cs_rise = cs_n && !cs_prev_q;
    assign full_byte = (bit_cnt_q == 5'd8);
    assign commit = cs_rise && full_byte && (state_q == st_wdata);
    assign is_write = (shift_q == CMD_CLK_WR) || (shift_q == CMD_CHSEL_WR)
        || (shift_q == CMD_LATCH_WR) || (shift_q == CMD_DIR_WR)
        || (shift_q == CMD_MUX_WR);
    assign is_read = (shift_q == CMD_CLK_RD) || (shift_q == CMD_CHSEL_RD)
        || (shift_q == CMD_PIN_RD) || (shift_q == CMD_DIR_RD)
        || (shift_q == CMD_MUX_RD);

    always_comb
    begin
        state_d = state_q;
        if (cs_rise)
        begin
            case (state_q)
                st_cmd:
                    if (full_byte && is_write)
                        state_d = st_wdata;
                    else if (full_byte && is_read)
                        state_d = st_rdata;
                    else
                        state_d = st_cmd;
                default:
                    state_d = st_cmd;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!int_rst_n)
        begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            bit_cnt_q <= 5'd0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            tx_q <= 8'h00;
            state_q <= st_cmd;
            serial_data_oe <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= serial_port_clock;
            cs_prev_q <= cs_n;
            state_q <= state_d;
            if (cs_fall)
                bit_cnt_q <= 5'd0;
            else if (sclk_rise && bit_cnt_q != 5'd31)
                bit_cnt_q <= bit_cnt_q + 5'd1;
            if (sclk_rise)
                shift_q <= {shift_q[6:0], serial_data_in};
            if (cs_rise && full_byte && state_q == st_cmd)
                cmd_q <= shift_q;
            if (cs_fall)
                tx_q <= rd_value;
            else if (sclk_fall && bit_cnt_q != 5'd0)
                tx_q <= {tx_q[6:0], 1'b0};
            serial_data_oe <= !cs_n && !cs_fall && state_q == st_rdata;
        end
    end
    assign serial_data_out = tx_q[7];

    // chip select held low for 16 clock edges resets on release
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            cs_reset_q <= 1'b0;
        else
            cs_reset_q <= cs_rise
                && bit_cnt_q >= 5'(CS_RESET_EDGES);
    end

    // ==================================================
    // configuration registers
    logic [7:0] clk_cfg_q;
    logic [7:0] channel_select_q;
    logic [7:0] mux_cfg_q;
    logic [31:0] lock_cnt_q;
    logic lock_run_q;
    logic mux_active;

    assign mux_active = clk_cfg_q[CLK_SRC_BIT] && mux_cfg_q[MUX_EN_BIT];

    always_ff @(posedge core_clk)
    begin
        if (!int_rst_n)
        begin
            clk_cfg_q <= CLK_CFG_RST;
            channel_select_q <= CHAN_SEL_RST;
            mux_cfg_q <= MUX_CFG_RST;
            clock_fail_flag <= 1'b1;
            lock_run_q <= 1'b0;
            lock_cnt_q <= 32'd0;
            clock_source_select <= 1'b0;
        end
        else
        begin
            if (commit && cmd_q == CMD_CLK_WR)
                clk_cfg_q <= shift_q;
            if (commit && cmd_q == CMD_CHSEL_WR)
                channel_select_q <= shift_q;
            if (commit && cmd_q == CMD_MUX_WR)
                mux_cfg_q <= shift_q;
            clock_source_select <= clk_cfg_q[CLK_SRC_BIT];
            if (commit && cmd_q == CMD_CLK_WR)
            begin
                lock_run_q <= 1'b1;
                lock_cnt_q <= 32'd0;
            end
            else if (lock_run_q && lock_cnt_q == 32'(CLK_LOCK_CYCLES - 1))
            begin
                lock_run_q <= 1'b0;
                clock_fail_flag <= 1'b0;
            end
            else if (lock_run_q)
                lock_cnt_q <= lock_cnt_q + 32'd1;
        end
    end

    // ==================================================
    // multiplex strobe timing
    logic slot_en;
    logic [4:0] slot_q;
    logic strobe_on;
    logic en_first;
    logic en_alt;
    logic [15:0] on_cyc_q;

    slot_tick u_slot_tick (
        .core_clk(core_clk),
        .reset_n(int_rst_n),
        .run(mux_active),
        .tick(slot_en)
    );

    assign strobe_on = mux_active && slot_q < 5'(STROBE_SLOTS);
    // detect latches are masked for one slot after each edge
    assign en_first = !mux_active
        || slot_q >= 5'(STROBE_SLOTS + MASK_SLOTS);
    assign en_alt = mux_active && slot_q >= 5'(MASK_SLOTS)
        && slot_q < 5'(STROBE_SLOTS);

    always_ff @(posedge core_clk)
    begin
        if (!int_rst_n)
        begin
            slot_q <= 5'd0;
            mux_strobe_out <= 1'b0;
            mux_strobe_oe <= 1'b0;
            on_cyc_q <= 16'h0000;
        end
        else
        begin
            if (!mux_active)
                slot_q <= 5'd0;
            else if (slot_en)
                slot_q <= (slot_q == 5'(FRAME_SLOTS - 1)) ? 5'd0
                    : slot_q + 5'd1;
            mux_strobe_oe <= mux_active;
            mux_strobe_out <= strobe_on ^ mux_cfg_q[STB_POL_BIT];
            on_cyc_q <= strobe_on ? on_cyc_q + 16'h0001 : 16'h0000;
        end
    end

    // ==================================================
    // channels and broadcast writes
    logic [7:0] ch_rd [NUM_CH];
    logic [7:0] dir_rd;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            line_channel u_ch (
                .core_clk(core_clk),
                .reset_n(int_rst_n),
                .wr_latch(commit && cmd_q == CMD_LATCH_WR
                    && channel_select_q[g]),
                .wr_dir(commit && cmd_q == CMD_DIR_WR
                    && channel_select_q[g]),
                .wr_data(shift_q),
                .en_first(en_first),
                .en_alt(en_alt),
                .mux_active(mux_active),
                .pin_in(line_io_in[g*5 +: 5]),
                .pin_out(line_io_out[g*5 +: 5]),
                .pin_oe(line_io_oe[g*5 +: 5]),
                .readback(ch_rd[g]),
                .second_status(realtime_second_status[g])
            );
        end
    endgenerate

    // reads answer for the lowest enabled channel
    logic [7:0] sel_rd;
    assign sel_rd = channel_select_q[0] ? ch_rd[0]
        : channel_select_q[1] ? ch_rd[1]
        : channel_select_q[2] ? ch_rd[2]
        : channel_select_q[3] ? ch_rd[3] : 8'h00;
    assign dir_rd = {clock_fail_flag, 7'h00};
    assign rd_value = (cmd_q == CMD_CLK_RD) ? clk_cfg_q
        : (cmd_q == CMD_CHSEL_RD) ? channel_select_q
        : (cmd_q == CMD_PIN_RD) ? sel_rd
        : (cmd_q == CMD_DIR_RD) ? dir_rd
        : (cmd_q == CMD_MUX_RD) ? mux_cfg_q : 8'h00;

    // ==================================================
    // checks
    property p_cs_reset;
        @(posedge core_clk) disable iff (!reset_n)
        cs_rise && bit_cnt_q >= 5'(CS_RESET_EDGES) |=> cs_reset_q
            ##1 channel_select_q == CHAN_SEL_RST;
    endproperty
    a_cs_reset: assert property (p_cs_reset)
        else $error("chip select hold did not reset");
    property p_pin_reset;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(reset_n) |-> clock_fail_flag && !mux_strobe_oe;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin did not reset state");
    property p_fail_clear;
        @(posedge core_clk) disable iff (!int_rst_n)
        lock_run_q && lock_cnt_q == 32'(CLK_LOCK_CYCLES - 1)
            && !(commit && cmd_q == CMD_CLK_WR) |=> !clock_fail_flag;
    endproperty
    a_fail_clear: assert property (p_fail_clear)
        else $error("clock fail flag overdue");
    property p_chan_write;
        @(posedge core_clk) disable iff (!int_rst_n)
        commit && cmd_q == CMD_LATCH_WR && channel_select_q[1]
            |=> line_io_out[9:5] == $past(shift_q[4:0]);
    endproperty
    a_chan_write: assert property (p_chan_write)
        else $error("enabled channel missed a write");
    property p_strobe_width;
        @(posedge core_clk) disable iff (!int_rst_n)
        $fell(strobe_on) && mux_active |-> $past(on_cyc_q) + 16'h0001
            == 16'(STROBE_CYC);
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width wrong");
    property p_strobe_idle;
        @(posedge core_clk) disable iff (!int_rst_n)
        !mux_active |=> !mux_strobe_oe;
    endproperty
    a_strobe_idle: assert property (p_strobe_idle)
        else $error("strobe pin driven while disabled");
    property p_polarity;
        @(posedge core_clk) disable iff (!int_rst_n)
        mux_active ##1 mux_strobe_oe |-> mux_strobe_out
            == ($past(strobe_on) ^ $past(mux_cfg_q[STB_POL_BIT]));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("strobe polarity wrong");
    property p_mask;
        @(posedge core_clk) disable iff (!int_rst_n)
        mux_active && (slot_q == 5'h00 || slot_q == 5'h02)
            |-> !en_first && !en_alt;
    endproperty
    a_mask: assert property (p_mask)
        else $error("detect latch open in mask window");
endmodule // line_io_ctrl

//--- tb/slic_quad_model.sv
// behavioural model of the four line interface chips on the channel pins
`timescale 1ns/1ps
module slic_quad_model
#(
    parameter int SETTLE_CYC = 1000
)
(
    input wire logic core_clk,
    input wire logic [19:0] line_io_out,
    input wire logic [19:0] line_io_oe,
    input wire logic mux_strobe_out,
    input wire logic mux_strobe_oe,
    input wire logic strobe_active_high,
    input wire logic [3:0] loop_state,
    input wire logic [3:0] gk_state,
    input wire logic [19:0] pull_level,
    output logic [19:0] line_io_in
);
    logic strobe_pin;
    logic sel_gk;
    logic sel_q = 1'b0;
    int settle_q = 0;
    logic unsettled;
    logic [3:0] target;
    logic [3:0] line_detector_out;
    logic [19:0] ext;
    // ==================================================
    // detector steering
    // undriven strobe pin is grounded
    assign strobe_pin = mux_strobe_oe ? mux_strobe_out : 1'b0;
    assign sel_gk = (strobe_pin == strobe_active_high);
    always_ff @(posedge core_clk)
    begin
        sel_q <= sel_gk;
        if (sel_gk != sel_q)
            settle_q <= SETTLE_CYC;
        else if (settle_q != 0)
            settle_q <= settle_q - 1;
    end
    // detector shows the wrong state until it settles
    assign unsettled = (settle_q != 0) || (sel_gk != sel_q);
    assign target = sel_gk ? gk_state : loop_state;
    assign line_detector_out = unsettled ? ~target : target;
    // ==================================================
    // pin levels
    always_comb
    begin
        ext = pull_level;
        for (int c = 0; c < 4; c++)
        begin
            ext[c * 5] = line_detector_out[c];
        end
    end
    assign line_io_in = (line_io_oe & line_io_out) | (~line_io_oe & ext);
endmodule // slic_quad_model

//--- tb/tb_line_io_detect_mux_control.sv
// self-checking bench for the line control block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module tb_line_io_detect_mux_control;
    import line_ctl_pkg::*;
    localparam int LOCK_CYC = 50;
    localparam int PERIOD_CYC = FRAME_SLOTS * SLOT_CYC;
    localparam int LIMIT_CYC = 100000;
    logic core_clk;
    logic reset_n;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic serial_data_out;
    logic serial_data_oe;
    logic [19:0] line_io_in;
    logic [19:0] line_io_out;
    logic [19:0] line_io_oe;
    logic mux_strobe_out;
    logic mux_strobe_oe;
    logic [3:0] realtime_second_status;
    logic clock_source_select;
    logic clock_fail_flag;
    logic [3:0] loop_state = 4'hA;
    logic [3:0] gk_state = 4'h3;
    logic [7:0] rdat;
    logic oe_hi;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    line_io_ctrl #(.CLK_LOCK_CYCLES(LOCK_CYC)) u_line_io_ctrl (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cs_n(cs_n),
        .serial_port_clock(sclk),
        .serial_data_in(sdi),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe),
        .line_io_in(line_io_in),
        .line_io_out(line_io_out),
        .line_io_oe(line_io_oe),
        .mux_strobe_out(mux_strobe_out),
        .mux_strobe_oe(mux_strobe_oe),
        .realtime_second_status(realtime_second_status),
        .clock_source_select(clock_source_select),
        .clock_fail_flag(clock_fail_flag)
    );
    slic_quad_model u_slic_quad_model (
        .core_clk(core_clk),
        .line_io_out(line_io_out),
        .line_io_oe(line_io_oe),
        .mux_strobe_out(mux_strobe_out),
        .mux_strobe_oe(mux_strobe_oe),
        .strobe_active_high(1'b1),
        .loop_state(loop_state),
        .gk_state(gk_state),
        .pull_level(20'hFFFFF),
        .line_io_in(line_io_in)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == LIMIT_CYC)
        begin
            err_total++;
            final_report();
        end
    end
    // ==================================================
    // access tasks
    task final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic rst;
        @(posedge core_clk) reset_n <= 1'b0;
        idle(4);
        reset_n <= 1'b1;
        idle(1);
    endtask
    // one select period with k serial clocks, msb first
    task automatic xfer(input logic [7:0] w, input int k,
                        output logic [7:0] r);
        logic [7:0] sh;
        sh = w;
        r = 8'h00;
        @(posedge core_clk) cs_n <= 1'b0;
        idle(2);
        for (int i = 0; i < k; i++)
        begin
            sdi <= sh[7];
            sh = {sh[6:0], 1'b0};
            idle(2);
            r = {r[6:0], serial_data_out};
            oe_hi = serial_data_oe;
            sclk <= 1'b1;
            idle(2);
            sclk <= 1'b0;
        end
        idle(2);
        cs_n <= 1'b1;
        idle(3);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        xfer(cmd, 8, rdat);
        xfer(d, 8, rdat);
        `CHK(oe_hi, 1'b0)
    endtask
    // only this device is selected during reads
    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        xfer(cmd, 8, rdat);
        xfer(8'h00, 8, rdat);
        `CHK(rdat, exp)
        `CHK(oe_hi, 1'b1)
    endtask
    task automatic run_lvl(input logic v, output int k);
        k = 0;
        while (mux_strobe_out === v && k < PERIOD_CYC)
        begin
            @(posedge core_clk);
            k++;
        end
    endtask
    // ==================================================
    // test sequence
    initial
    begin
        reset_n = 1'b0;
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        rst();
        `CHK(clock_fail_flag, 1'b1)
        `CHK(line_io_oe, 20'h00000)
        idle(100);
        rd_chk(CMD_DIR_RD, 8'h80);
        rd_chk(CMD_CHSEL_RD, 8'h0F);
        wr(CMD_CLK_WR, 8'h10);
        `CHK(clock_source_select, 1'b1)
        idle(LOCK_CYC - 10);
        `CHK(clock_fail_flag, 1'b1)
        idle(20);
        `CHK(clock_fail_flag, 1'b0)
        rd_chk(CMD_DIR_RD, 8'h00);
        rd_chk(CMD_CLK_RD, 8'h10);
        wr(CMD_CHSEL_WR, 8'h02);
        wr(CMD_LATCH_WR, 8'h0B);
        wr(CMD_DIR_WR, 8'h1A);
        `CHK(line_io_out, 20'h00160)
        `CHK(line_io_oe, 20'h00340)
        rd_chk(CMD_PIN_RD, 8'h0F);
        wr(CMD_DIR_WR, 8'h3A);
        `CHK(line_io_oe, 20'h00000)
        rd_chk(CMD_PIN_RD, 8'h0F);
        wr(CMD_CHSEL_WR, 8'h0F);
        wr(CMD_LATCH_WR, 8'h0A);
        `CHK(line_io_out, 20'h5294A)
        wr(CMD_DIR_WR, 8'h1F);
        `CHK(line_io_oe, 20'hFFFFF)
        wr(CMD_LATCH_WR, 8'h00);
        `CHK(realtime_second_status, 4'h0)
        wr(CMD_DIR_WR, 8'h00);
        idle(1);
        `CHK(realtime_second_status, 4'hF)
        wr(CMD_CLK_WR, 8'h00);
        wr(CMD_MUX_WR, 8'h80);
        `CHK(mux_strobe_oe, 1'b0)
        rd_chk(CMD_MUX_RD, 8'h80);
        wr(CMD_CLK_WR, 8'h10);
        `CHK(mux_strobe_oe, 1'b1)
        run_lvl(1'b0, n);
        run_lvl(1'b1, n);
        run_lvl(1'b0, n);
        `CHK(n, PERIOD_CYC - STROBE_CYC)
        run_lvl(1'b1, n);
        `CHK(n, STROBE_CYC)
        `CHK(realtime_second_status, gk_state)
        rd_chk(CMD_PIN_RD, 8'h3E);
        wr(CMD_MUX_WR, 8'hC0);
        `CHK(mux_strobe_out, 1'b1)
        wr(CMD_MUX_WR, 8'h00);
        `CHK(mux_strobe_oe, 1'b0)
        `CHK(realtime_second_status, 4'hF)
        wr(CMD_CHSEL_WR, 8'h03);
        xfer(8'h00, 16, rdat);
        `CHK(clock_fail_flag, 1'b1)
        `CHK(clock_source_select, 1'b0)
        rd_chk(CMD_CHSEL_RD, 8'h0F);
        wr(CMD_CHSEL_WR, 8'h05);
        rst();
        rd_chk(CMD_CHSEL_RD, 8'h0F);
        final_report();
    end
endmodule // tb_line_io_detect_mux_control
